// ==== common/uhlpr_pkg.sv ====
// constants for the list pointer and interrupt mask register group
package uhlpr_pkg;
    // register offsets from the controller base address
    localparam logic [7:0] UHLPR_OFS_MASK_SET = 8'h10;
    localparam logic [7:0] UHLPR_OFS_MASK_CLR = 8'h14;
    localparam logic [7:0] UHLPR_OFS_COMM_AREA = 8'h18;
    localparam logic [7:0] UHLPR_OFS_PERIODIC = 8'h1c;
    // interrupt mask bit positions
    localparam int UHLPR_BIT_MASTER_GATE = 31;
    localparam int UHLPR_BIT_OWNER_CHANGE = 30;
    localparam int UHLPR_BIT_ROOT_PORT_CHANGE = 6;
    localparam int UHLPR_BIT_FRAME_WRAP = 5;
    localparam int UHLPR_BIT_FATAL_ERROR = 4;
    localparam int UHLPR_BIT_RESUME_DETECT = 3;
    localparam int UHLPR_BIT_FRAME_BEGIN = 2;
    localparam int UHLPR_BIT_DONE_WRITEBACK = 1;
    localparam int UHLPR_BIT_SCHED_OVERRUN = 0;
    // implemented mask bits; 29 to 7 are reserved
    localparam logic [31:0] UHLPR_MASK_IMPL = 32'hc000007f;
    // field layouts
    localparam int UHLPR_COMM_AREA_LSB = 8;
    localparam int UHLPR_PERIODIC_LSB = 4;
    localparam logic [31:0] UHLPR_COMM_AREA_KEEP = 32'hffffff00;
    localparam logic [31:0] UHLPR_PERIODIC_KEEP = 32'hfffffff0;
    // values after reset
    localparam logic [31:0] UHLPR_MASK_RESET = 32'h00000000;
    localparam logic [31:0] UHLPR_COMM_AREA_RESET = 32'h00000000;
    localparam logic [31:0] UHLPR_PERIODIC_RESET = 32'h00000000;
    localparam logic [31:0] UHLPR_UNMAPPED_READ = 32'h00000000;
    // read answer latency in sys_clk cycles
    localparam int UHLPR_READ_LATENCY = 1;
endpackage

// ==== rtl/uhlpr_mask_cell.sv ====
// one interrupt mask bit with set, clear and reset
`timescale 1ns/100ps
module uhlpr_mask_cell
    import uhlpr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic clear_all,
    input wire logic set_req,
    input wire logic clr_req,
    output logic mask_bit
);

    // set and clear never meet: they come from different offsets
    always_ff @(posedge sys_clk)
    begin
        if (clear_all)
        begin
            mask_bit <= 1'b0; // see RQ4
        end
        else if (set_req)
        begin
            mask_bit <= 1'b1;
        end
        else if (clr_req)
        begin
            mask_bit <= 1'b0; // see RQ1
        end
    end

endmodule

// ==== rtl/uhlpr_regs.sv ====
// interrupt mask clear, communication area base and periodic pointer
//
// Overview of operation
// RQ1: a one to a clear bit stops its source; 31 gate, 30 owner, 29..7 spare.
// RQ2: 6 port, 5 wrap, 4 fatal, 3 resume, 2 frame, 1 writeback, 0 overrun.
// RQ3: a zero written to a mask-clear bit leaves that mask bit as it was.
// RQ4: hardware or software reset leaves the gate and every mask bit off.
// RQ5: a one to mask-clear clears the enable bit; a read returns the enables.
// RQ6: comm area base is a 24-bit read-write field in 31..8, reset zero.
// RQ7: bits 7..0 of the comm area base read zero, for 256-byte alignment.
// RQ8: software writes all ones and counts low zero bits to find alignment.
// RQ9: software writes zero to every reserved bit.
// RQ10: periodic pointer is read-only 31..4, low bits read zero, reset zero.
// RQ11: the periodic pointer moves each time the engine ends a descriptor.
// RQ12: software only reads the periodic pointer to see the active descriptor.
// RQ13: writes to the periodic pointer are ignored.
`timescale 1ns/100ps
module uhlpr_regs
    import uhlpr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic ped_done,
    input wire logic [31:0] ped_addr,
    output logic [31:0] reg_rdata,
    output logic reg_rdata_valid,
    output logic [31:0] irq_mask,
    output logic [31:0] comm_area_base,
    output logic [31:0] periodic_current
);

    ////////////////////////////////////////////////////////////////////////
    logic wr_mask_set;
    logic wr_mask_clr;
    logic wr_comm_area;
    logic clear_all;

    assign wr_mask_set = reg_wr && (reg_addr == UHLPR_OFS_MASK_SET);
    assign wr_mask_clr = reg_wr && (reg_addr == UHLPR_OFS_MASK_CLR);
    assign wr_comm_area = reg_wr && (reg_addr == UHLPR_OFS_COMM_AREA);
    assign clear_all = reset || soft_reset; // see RQ4

    ////////////////////////////////////////////////////////////////////////
    // mask bits; reserved positions hold no state and read zero
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_mask
            if (UHLPR_MASK_IMPL[gi]) // see RQ1 RQ2
            begin : g_impl
                uhlpr_mask_cell u_cell (
                    .sys_clk(sys_clk),
                    .clear_all(clear_all),
                    .set_req(wr_mask_set && reg_wdata[gi]),
                    .clr_req(wr_mask_clr && reg_wdata[gi]), // see RQ1 RQ3
                    .mask_bit(irq_mask[gi])
                );
            end
            else
            begin : g_rsvd
                assign irq_mask[gi] = 1'b0; // see RQ1
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // low bits are never stored, so read-back reveals the alignment
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            comm_area_base <= UHLPR_COMM_AREA_RESET;
        end
        else if (wr_comm_area)
        begin
            comm_area_base <= reg_wdata & UHLPR_COMM_AREA_KEEP; // see RQ6 RQ7
        end
    end

    // only the list engine moves this pointer; bus writes have no path
    always_ff @(posedge sys_clk) // see RQ13
    begin
        if (reset)
        begin
            periodic_current <= UHLPR_PERIODIC_RESET;
        end
        else if (ped_done) // see RQ11
        begin
            periodic_current <= ped_addr & UHLPR_PERIODIC_KEEP; // see RQ10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            reg_rdata <= UHLPR_UNMAPPED_READ;
            reg_rdata_valid <= 1'b0;
        end
        else
        begin
            reg_rdata_valid <= reg_rd;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    UHLPR_OFS_MASK_SET: reg_rdata <= irq_mask;
                    UHLPR_OFS_MASK_CLR: reg_rdata <= irq_mask; // see RQ5
                    UHLPR_OFS_COMM_AREA: reg_rdata <= comm_area_base;
                    UHLPR_OFS_PERIODIC: reg_rdata <= periodic_current;
                    default: reg_rdata <= UHLPR_UNMAPPED_READ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_one_clears_mask: assert property ( // see RQ1
        @(posedge sys_clk) disable iff (reset)
        wr_mask_clr && !soft_reset
        |=> (irq_mask & $past(reg_wdata)) == 32'h0)
        else $error("mask bit survived a one written to clear");

    // flops hold x before the first reset edge, hence the disable
    a_reserved_mask_zero: assert property ( // see RQ1
        @(posedge sys_clk) disable iff (reset)
        irq_mask[29:7] == 23'h0)
        else $error("reserved mask bit is set");

    a_low_bits_map: assert property ( // see RQ2
        @(posedge sys_clk) disable iff (reset)
        wr_mask_clr && !soft_reset
        |=> irq_mask[6:0] == ($past(irq_mask[6:0]) & ~$past(reg_wdata[6:0])))
        else $error("low mask bits mapped wrongly");

    a_zero_write_keeps: assert property ( // see RQ3
        @(posedge sys_clk) disable iff (reset)
        wr_mask_clr && !soft_reset |=>
        (irq_mask & ~$past(reg_wdata))
            == ($past(irq_mask) & ~$past(reg_wdata)))
        else $error("zero written to clear changed the mask");

    a_reset_gate_off: assert property ( // see RQ4
        @(posedge sys_clk) disable iff (reset)
        $past(reset) || $past(soft_reset) |-> irq_mask == UHLPR_MASK_RESET)
        else $error("mask not disabled after reset");

    a_clear_reads_mask: assert property ( // see RQ5
        @(posedge sys_clk) disable iff (reset)
        reg_rd && reg_addr == UHLPR_OFS_MASK_CLR
        |=> reg_rdata_valid && reg_rdata == $past(irq_mask))
        else $error("mask-clear read does not return the mask");

    a_set_reaches_mask: assert property ( // see RQ5
        @(posedge sys_clk) disable iff (reset)
        wr_mask_set && !soft_reset |=>
        (irq_mask & $past(reg_wdata) & UHLPR_MASK_IMPL)
            == ($past(reg_wdata) & UHLPR_MASK_IMPL))
        else $error("a one written to mask-set did not set the bit");

    a_read_valid_pulse: assert property ( // see RQ5
        @(posedge sys_clk) disable iff (reset)
        !$past(reset) |-> reg_rdata_valid == $past(reg_rd))
        else $error("read valid not one cycle after the read strobe");

    a_rdata_held: assert property ( // see RQ5
        @(posedge sys_clk) disable iff (reset)
        !$past(reg_rd) && !$past(reset) |-> $stable(reg_rdata))
        else $error("read data changed without a read");

    // a second write in the next cycle may move the field again
    a_comm_write_held: assert property ( // see RQ6
        @(posedge sys_clk) disable iff (reset)
        wr_comm_area |=> comm_area_base[31:8] == $past(reg_wdata[31:8])
        ##1 ($past(wr_comm_area) || $stable(comm_area_base)))
        else $error("communication area base not written or not held");

    a_soft_keeps_comm: assert property ( // see RQ6
        @(posedge sys_clk) disable iff (reset)
        soft_reset && !wr_comm_area |=> $stable(comm_area_base))
        else $error("software reset disturbed the comm area base");

    a_comm_low_zero: assert property ( // see RQ7
        @(posedge sys_clk) disable iff (reset)
        reg_rd && reg_addr == UHLPR_OFS_COMM_AREA
        |=> reg_rdata[7:0] == 8'h00)
        else $error("communication area base low bits read nonzero");

    a_periodic_update: assert property ( // see RQ11
        @(posedge sys_clk) disable iff (reset)
        ped_done
        |=> periodic_current == ($past(ped_addr) & UHLPR_PERIODIC_KEEP))
        else $error("periodic pointer not updated by the list engine");

    a_periodic_low_zero: assert property ( // see RQ10
        @(posedge sys_clk) disable iff (reset)
        periodic_current[3:0] == 4'h0)
        else $error("periodic pointer low bits nonzero");

    a_periodic_read_back: assert property ( // see RQ10
        @(posedge sys_clk) disable iff (reset)
        reg_rd && reg_addr == UHLPR_OFS_PERIODIC
        |=> reg_rdata == $past(periodic_current))
        else $error("periodic pointer read returned another value");

    a_periodic_no_write: assert property ( // see RQ13
        @(posedge sys_clk) disable iff (reset)
        reg_wr && reg_addr == UHLPR_OFS_PERIODIC && !ped_done
        |=> $stable(periodic_current))
        else $error("bus write altered the periodic pointer");

    c_master_gate_clear: cover property (
        @(posedge sys_clk) disable iff (reset)
        irq_mask[UHLPR_BIT_MASTER_GATE] ##1 !irq_mask[UHLPR_BIT_MASTER_GATE]);
    c_comm_probe: cover property (
        @(posedge sys_clk) disable iff (reset)
        wr_comm_area && reg_wdata == 32'hffffffff ##2
        reg_rd && reg_addr == UHLPR_OFS_COMM_AREA);
    c_periodic_read: cover property (
        @(posedge sys_clk) disable iff (reset)
        ped_done ##1 reg_rd && reg_addr == UHLPR_OFS_PERIODIC);
    c_soft_reset_clear: cover property (
        @(posedge sys_clk) disable iff (reset)
        soft_reset && irq_mask != 32'h0 ##1 irq_mask == 32'h0);

endmodule

// ==== test/usb_host_list_pointer_regs_tb_top.sv ====
// self-checking bench for the mask clear, comm area and periodic registers
`timescale 1ns/100ps
module usb_host_list_pointer_regs_tb_top
    import uhlpr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic soft_reset = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic ped_done = 1'b0;
    logic [31:0] ped_addr = 32'h00000000;
    logic [31:0] reg_rdata;
    logic reg_rdata_valid;
    logic [31:0] irq_mask;
    logic [31:0] comm_area_base;
    logic [31:0] periodic_current;
    int n_errors = 0;
    int n_tests = 0;
    int bits[9] = '{31, 30, 6, 5, 4, 3, 2, 1, 0};
    logic [31:0] exp;

    always #25 sys_clk = ~sys_clk;

    uhlpr_regs DUT (.sys_clk(sys_clk), .reset(reset), .soft_reset(soft_reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .ped_done(ped_done), .ped_addr(ped_addr),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .irq_mask(irq_mask), .comm_area_base(comm_area_base),
        .periodic_current(periodic_current));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // tasks are entered 5 ns after a rising edge and leave there too
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #5 reg_wr = 1'b0;
        // stale data would hide a missing strobe qualification
        reg_wdata = ~d;
        // an idle edge keeps the next call from reassigning the strobe
        @(posedge sys_clk);
        #5;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #5 reg_rd = 1'b0;
        chk({31'h0, reg_rdata_valid}, 32'h00000001);
        chk(reg_rdata, want);
        @(posedge sys_clk);
        // valid stands for one cycle only
        #5 chk({31'h0, reg_rdata_valid}, 32'h00000000);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        // roughly 2000 cycles, about 28 times the expected run
        #100000;
        n_errors++;
        give_verdict();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        #5 reset = 1'b0;
        chk(irq_mask, UHLPR_MASK_RESET);
        rd(UHLPR_OFS_MASK_CLR, 32'h00000000);
        rd(UHLPR_OFS_COMM_AREA, 32'h00000000);
        rd(UHLPR_OFS_PERIODIC, 32'h00000000);
        // reserved bits must not be stored
        wr(UHLPR_OFS_MASK_SET, 32'hffffffff);
        rd(UHLPR_OFS_MASK_CLR, 32'hc000007f);
        wr(UHLPR_OFS_MASK_CLR, 32'h00000000);
        chk(irq_mask, 32'hc000007f);
        exp = 32'hc000007f;
        foreach (bits[i])
        begin
            wr(UHLPR_OFS_MASK_CLR, 32'h00000001 << bits[i]);
            exp[bits[i]] = 1'b0;
            chk(irq_mask, exp);
        end
        rd(UHLPR_OFS_MASK_CLR, 32'h00000000);
        wr(UHLPR_OFS_COMM_AREA, 32'hffffffff);
        rd(UHLPR_OFS_COMM_AREA, 32'hffffff00);
        wr(UHLPR_OFS_COMM_AREA, 32'h12345678);
        rd(UHLPR_OFS_COMM_AREA, 32'h12345600);
        chk(comm_area_base, 32'h12345600);
        ped_addr = 32'habcdef1f;
        ped_done = 1'b1;
        @(posedge sys_clk);
        #5 ped_done = 1'b0;
        ped_addr = 32'h54321ee0;
        chk(periodic_current, 32'habcdef10);
        rd(UHLPR_OFS_PERIODIC, 32'habcdef10);
        wr(UHLPR_OFS_PERIODIC, 32'h11111110);
        rd(UHLPR_OFS_PERIODIC, 32'habcdef10);
        rd(8'h20, UHLPR_UNMAPPED_READ);
        // software reset clears the mask only
        wr(UHLPR_OFS_MASK_SET, 32'h80000041);
        chk(irq_mask, 32'h80000041);
        soft_reset = 1'b1;
        @(posedge sys_clk);
        #5 soft_reset = 1'b0;
        chk(irq_mask, 32'h00000000);
        rd(UHLPR_OFS_COMM_AREA, 32'h12345600);
        chk(periodic_current, 32'habcdef10);
        // hardware reset in mid-run returns everything to zero
        wr(UHLPR_OFS_MASK_SET, 32'h80000001);
        chk(irq_mask, 32'h80000001);
        reset = 1'b1;
        @(posedge sys_clk);
        #5 reset = 1'b0;
        chk(irq_mask, 32'h00000000);
        rd(UHLPR_OFS_COMM_AREA, 32'h00000000);
        chk(comm_area_base, 32'h00000000);
        chk(periodic_current, 32'h00000000);
        rd(UHLPR_OFS_PERIODIC, 32'h00000000);
        give_verdict();
    end
endmodule
